// ### hw/rdcd_top.sv
// rdcd_top: device-side read dma command decoder, 28-bit and 48-bit.
// assumes a classic wishbone master, a media source on the same clock
// and a host slave-dma channel whose acknowledge arrives from a pin.
//
// Overview of operation
// - code 25h starts extended 48-bit dma read
// - retry bit of 28-bit code is ignored
// - head field: chs head or lba 24-27
// - sector count returns sectors not transferred
// - return last sector/cylinder or lba 0-23
// - head field returns head or lba 24-27
// - sector data moves as 16-bit words
// - each word paced by dmarq, host moves it
// - one interrupt per command after status valid
// - uncorrectable error stops at failing sector
// - extended count: current low, previous high byte
// - extended count zero means 65,536 sectors
// - 48-bit lba from current and previous writes
// - error lba readback selected by hob bit
// - 28-bit count zero means 256 sectors
// - codes c8h and c9h are 28-bit read
// - lba mode: sector, cylinder give bits 0-23
//
// The Wishbone register port and the address map were left to the implementer.
`timescale 1ns/1ns
module rdcd_top (
   input  wire logic        clk_i,
   input  wire logic        rst_i,
   input  wire logic        wb_cyc_i,
   input  wire logic        wb_stb_i,
   input  wire logic        wb_we_i,
   input  wire logic [7:0]  wb_adr_i,
   input  wire logic [3:0]  wb_sel_i,
   input  wire logic [31:0] wb_dat_i,
   output logic      [31:0] wb_dat_o,
   output logic             wb_ack_o,
   output logic             dmarq_o,
   output logic      [15:0] dma_data_o,
   input  wire logic        dmack_i,
   output logic             intrq_o,
   output logic             media_req_o,
   output logic      [47:0] media_lba_o,
   input  wire logic        media_vld_i,
   input  wire logic [15:0] media_word_i,
   input  wire logic        media_unc_i
);

   typedef enum logic [1:0] {RDCD_IDLE, RDCD_FETCH, RDCD_OFFER} rdcd_state_e;

   rdcd_state_e        state_reg;
   rdcd_pkg::rdcd_tf_s count_reg;
   rdcd_pkg::rdcd_tf_s secnum_reg;
   rdcd_pkg::rdcd_tf_s cyllo_reg;
   rdcd_pkg::rdcd_tf_s cylhi_reg;
   logic [7:0]         feature_reg;
   logic [7:0]         devhead_reg;
   logic [7:0]         error_reg;
   logic               hob_reg;
   logic               busy_reg;
   logic               err_flag_reg;
   logic               ext_reg;
   logic               lba_mode_reg;
   logic [16:0]        remain_reg;
   logic [7:0]         word_cnt_reg;
   logic [47:0]        addr_reg;
   logic [15:0]        word_reg;
   logic               dmarq_reg;
   logic               intrq_reg;
   logic               media_req_reg;
   logic               ack_reg;
   logic [31:0]        rdata_reg;
   logic               ack_s1_reg;
   logic               ack_s2_reg;
   logic               ack_s3_reg;
   logic               ack_level_reg;

   logic               bus_req;
   logic               wr_take;
   logic               rd_take;
   logic               tf_write;
   logic               cmd_write;
   logic               is_rd28;
   logic               is_rd48;
   logic               word_taken;
   logic               sector_end;
   logic               last_sector;
   logic [16:0]        count28;
   logic [16:0]        count48;
   logic [47:0]        start_addr;
   logic [47:0]        addr_next;
   logic [7:0]         status_byte;
   logic [16:0]        remain_next;
   logic [7:0]         rd_byte;

   // ---------------- wishbone slave ----------------
   // a request is answered one edge after it is seen; writes land on the edge after that, as ack ends
   assign bus_req  = wb_cyc_i & wb_stb_i;
   assign wr_take  = ack_reg & bus_req & wb_we_i & wb_sel_i[0];
   assign rd_take  = ack_reg & bus_req & ~wb_we_i;
   // task file is frozen while a command runs
   assign tf_write  = wr_take & ~busy_reg;
   assign cmd_write = tf_write & (wb_adr_i == rdcd_pkg::OFS_CMD_STATUS);

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         ack_reg <= 1'b0;
      end else begin
         ack_reg <= bus_req & ~ack_reg;
      end
   end

   // status byte built from live state
   always_comb begin
      status_byte                           = 8'h00;
      status_byte[rdcd_pkg::ST_BUSY_BIT]    = busy_reg;
      status_byte[rdcd_pkg::ST_READY_BIT]   = 1'b1;
      status_byte[rdcd_pkg::ST_SEEK_BIT]    = 1'b1;
      status_byte[rdcd_pkg::ST_DRQ_BIT]     = dmarq_reg;
      status_byte[rdcd_pkg::ST_ERR_BIT]     = err_flag_reg;
   end

   // read mux; hob picks the previous (high order) bytes
   always_comb begin
      case (wb_adr_i)
         rdcd_pkg::OFS_SECTOR_CNT:  rd_byte = hob_reg ? count_reg.prev  : count_reg.cur;
         rdcd_pkg::OFS_SECTOR_NUM:  rd_byte = hob_reg ? secnum_reg.prev : secnum_reg.cur;
         rdcd_pkg::OFS_CYL_LOW:     rd_byte = hob_reg ? cyllo_reg.prev  : cyllo_reg.cur;
         rdcd_pkg::OFS_CYL_HIGH:    rd_byte = hob_reg ? cylhi_reg.prev  : cylhi_reg.cur;
         rdcd_pkg::OFS_DEV_HEAD:    rd_byte = devhead_reg;
         rdcd_pkg::OFS_CMD_STATUS:  rd_byte = status_byte;
         rdcd_pkg::OFS_ERROR:       rd_byte = error_reg;
         rdcd_pkg::OFS_DEV_CONTROL: rd_byte = {hob_reg, 7'h00};
         default:                   rd_byte = 8'h00; // feature is write-only
      endcase
   end

   // read data captured as ack rises, held while ack stands
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         rdata_reg <= 32'h00000000;
      end else if (bus_req & ~ack_reg) begin
         rdata_reg <= {24'h000000, rd_byte};
      end
   end

   // ---------------- dma acknowledge synchroniser ----------------
   // pin input: a change counts once the second and third stage agree
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         ack_s1_reg    <= 1'b0;
         ack_s2_reg    <= 1'b0;
         ack_s3_reg    <= 1'b0;
         ack_level_reg <= 1'b0;
      end else begin
         ack_s1_reg <= dmack_i;
         ack_s2_reg <= ack_s1_reg;
         ack_s3_reg <= ack_s2_reg;
         if (ack_s2_reg == ack_s3_reg) begin
            ack_level_reg <= ack_s3_reg;
         end
      end
   end

   // one word leaves per stable acknowledge rise while dmarq stands
   assign word_taken = dmarq_reg & ack_s2_reg & ack_s3_reg & ~ack_level_reg;

   // ---------------- command decode ----------------
   assign is_rd28 = (wb_dat_i[7:0] & rdcd_pkg::CMD_READ_DMA_MASK)
                    == rdcd_pkg::CMD_READ_DMA;
   assign is_rd48 = wb_dat_i[7:0] == rdcd_pkg::CMD_READ_DMA_EXT;

   assign count28 = (count_reg.cur == 8'h00) ? rdcd_pkg::COUNT28_ZERO_AS
                                              : {9'h000, count_reg.cur};
   assign count48 = ({count_reg.prev, count_reg.cur} == 16'h0000)
                    ? rdcd_pkg::COUNT48_ZERO_AS
                    : {1'b0, count_reg.prev, count_reg.cur};

   // starting address; 28-bit chs packs sector, cylinder and head alike
   always_comb begin
      if (is_rd48) begin
         start_addr = {cylhi_reg.prev, cyllo_reg.prev, secnum_reg.prev,
                       cylhi_reg.cur, cyllo_reg.cur, secnum_reg.cur};
      end else begin
         start_addr = {20'h00000, devhead_reg[3:0],
                       cylhi_reg.cur, cyllo_reg.cur, secnum_reg.cur};
      end
   end

   // next sector address: linear for lba, sector/head/cylinder walk for chs
   always_comb begin
      addr_next = addr_reg;
      if (ext_reg | lba_mode_reg) begin
         addr_next = addr_reg + 48'h000000000001;
      end else if (addr_reg[7:0] < rdcd_pkg::SECTORS_PER_TRACK) begin
         addr_next[7:0] = addr_reg[7:0] + 8'h01;
      end else begin
         addr_next[7:0] = 8'h01;
         if (addr_reg[27:24] < rdcd_pkg::HEADS_M1) begin
            addr_next[27:24] = addr_reg[27:24] + 4'h1;
         end else begin
            addr_next[27:24] = 4'h0;
            addr_next[23:8]  = addr_reg[23:8] + 16'h0001;
         end
      end
   end

   // the word counter wraps by itself, so it needs no clear between sectors
   assign sector_end  = word_taken & (word_cnt_reg == rdcd_pkg::WORDS_PER_SECTOR_M1);
   assign last_sector = remain_reg == 17'h00001;
   assign remain_next = remain_reg - 17'h00001;

   // ---------------- transfer sequencer ----------------
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         state_reg     <= RDCD_IDLE;
         busy_reg      <= 1'b0;
         ext_reg       <= 1'b0;
         lba_mode_reg  <= 1'b0;
         remain_reg    <= 17'h00000;
         word_cnt_reg  <= 8'h00;
         addr_reg      <= 48'h000000000000;
         media_req_reg <= 1'b0;
         dmarq_reg     <= 1'b0;
         word_reg      <= 16'h0000;
      end else begin
         case (state_reg)
            RDCD_IDLE: begin
               if (cmd_write & (is_rd28 | is_rd48)) begin
                  busy_reg      <= 1'b1;
                  ext_reg       <= is_rd48;
                  lba_mode_reg  <= devhead_reg[rdcd_pkg::LBA_MODE_BIT];
                  remain_reg    <= is_rd48 ? count48 : count28;
                  addr_reg      <= start_addr;
                  word_cnt_reg  <= 8'h00;
                  media_req_reg <= 1'b1;
                  state_reg     <= RDCD_FETCH;
               end
            end
            RDCD_FETCH: begin
               if (media_unc_i) begin
                  // failing sector: addr and remaining count stay as they are
                  media_req_reg <= 1'b0;
                  busy_reg      <= 1'b0;
                  state_reg     <= RDCD_IDLE;
               end else if (media_vld_i) begin
                  word_reg      <= media_word_i;
                  media_req_reg <= 1'b0;
                  dmarq_reg     <= 1'b1;
                  state_reg     <= RDCD_OFFER;
               end
            end
            RDCD_OFFER: begin
               if (word_taken) begin
                  dmarq_reg    <= 1'b0;
                  word_cnt_reg <= word_cnt_reg + 8'h01;
                  if (sector_end) begin
                     remain_reg <= remain_next;
                     if (last_sector) begin
                        // address is left on the last sector moved
                        busy_reg  <= 1'b0;
                        state_reg <= RDCD_IDLE;
                     end else begin
                        addr_reg      <= addr_next;
                        media_req_reg <= 1'b1;
                        state_reg     <= RDCD_FETCH;
                     end
                  end else begin
                     media_req_reg <= 1'b1;
                     state_reg     <= RDCD_FETCH;
                  end
               end
            end
            default: begin
               state_reg <= RDCD_IDLE;
            end
         endcase
      end
   end

   // ---------------- task file registers ----------------
   // each count, sector or cylinder write shifts current into previous, as the 48-bit form needs;
   // at command end the results overwrite both halves
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         count_reg   <= '{prev: rdcd_pkg::TF_RESET, cur: rdcd_pkg::TF_RESET};
         secnum_reg  <= '{prev: rdcd_pkg::TF_RESET, cur: rdcd_pkg::TF_RESET};
         cyllo_reg   <= '{prev: rdcd_pkg::TF_RESET, cur: rdcd_pkg::TF_RESET};
         cylhi_reg   <= '{prev: rdcd_pkg::TF_RESET, cur: rdcd_pkg::TF_RESET};
         devhead_reg <= rdcd_pkg::DEV_HEAD_RST;
         feature_reg <= rdcd_pkg::TF_RESET;
      end else if (busy_reg & (state_reg != RDCD_IDLE) &
                   ((state_reg == RDCD_FETCH & media_unc_i) |
                    (sector_end & last_sector))) begin
         // results: remaining count and last or failing address
         count_reg  <= '{prev: (sector_end ? remain_next[15:8] : remain_reg[15:8]),
                         cur:  (sector_end ? remain_next[7:0]  : remain_reg[7:0])};
         secnum_reg <= '{prev: addr_reg[31:24], cur: addr_reg[7:0]};
         cyllo_reg  <= '{prev: addr_reg[39:32], cur: addr_reg[15:8]};
         cylhi_reg  <= '{prev: addr_reg[47:40], cur: addr_reg[23:16]};
         if (!ext_reg) begin
            devhead_reg[3:0] <= addr_reg[27:24];
         end
      end else if (tf_write) begin
         case (wb_adr_i)
            rdcd_pkg::OFS_FEATURE:    feature_reg <= wb_dat_i[7:0];
            rdcd_pkg::OFS_SECTOR_CNT: count_reg   <= '{prev: count_reg.cur,
                                                       cur: wb_dat_i[7:0]};
            rdcd_pkg::OFS_SECTOR_NUM: secnum_reg  <= '{prev: secnum_reg.cur,
                                                       cur: wb_dat_i[7:0]};
            rdcd_pkg::OFS_CYL_LOW:    cyllo_reg   <= '{prev: cyllo_reg.cur,
                                                       cur: wb_dat_i[7:0]};
            rdcd_pkg::OFS_CYL_HIGH:   cylhi_reg   <= '{prev: cylhi_reg.cur,
                                                       cur: wb_dat_i[7:0]};
            rdcd_pkg::OFS_DEV_HEAD:   devhead_reg <= wb_dat_i[7:0];
            default: begin
            end
         endcase
      end
   end

   // readback selector; any task-file write returns it to the low bytes
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         hob_reg <= 1'b0;
      end else if (wr_take & (wb_adr_i == rdcd_pkg::OFS_DEV_CONTROL)) begin
         hob_reg <= wb_dat_i[rdcd_pkg::HOB_BIT];
      end else if (tf_write) begin
         hob_reg <= 1'b0;
      end
   end

   // ---------------- error and interrupt ----------------
   // error state is fixed when the command ends and cleared by the next one
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         error_reg    <= rdcd_pkg::ERR_RESET;
         err_flag_reg <= 1'b0;
      end else if (cmd_write) begin
         error_reg    <= rdcd_pkg::ERR_RESET;
         err_flag_reg <= ~(is_rd28 | is_rd48);
         error_reg[rdcd_pkg::ERR_ABORT_BIT] <= ~(is_rd28 | is_rd48);
      end else if ((state_reg == RDCD_FETCH) & media_unc_i) begin
         error_reg[rdcd_pkg::ERR_UNC_BIT] <= 1'b1;
         err_flag_reg                     <= 1'b1;
      end
   end

   // level interrupt: one per command, set when status is final,
   // dropped by a status read; a new ending wins over a same-cycle read
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         intrq_reg <= 1'b0;
      end else if (((state_reg == RDCD_FETCH) & media_unc_i) |
                   ((state_reg == RDCD_OFFER) & sector_end & last_sector) |
                   (cmd_write & ~(is_rd28 | is_rd48))) begin
         intrq_reg <= 1'b1;
      end else if ((rd_take & (wb_adr_i == rdcd_pkg::OFS_CMD_STATUS)) | cmd_write) begin
         intrq_reg <= 1'b0;
      end
   end

   // every output is a flip-flop, so no pin shows a decode glitch
   assign wb_ack_o    = ack_reg;
   assign wb_dat_o    = rdata_reg;
   assign dmarq_o     = dmarq_reg;
   assign dma_data_o  = word_reg;
   assign intrq_o     = intrq_reg;
   assign media_req_o = media_req_reg;
   assign media_lba_o = addr_reg;

endmodule // rdcd_top

// ### hw/rdcd_pkg.sv
// rdcd_pkg: register map, field positions, codes and sizes for the
// read-by-dma command decoder. assumes a 32-bit classic wishbone host.
package rdcd_pkg;

   // register word offsets (byte addresses), data in bits 7:0
   localparam logic [7:0] OFS_FEATURE     = 8'h04;
   localparam logic [7:0] OFS_SECTOR_CNT  = 8'h08;
   localparam logic [7:0] OFS_SECTOR_NUM  = 8'h0C;
   localparam logic [7:0] OFS_CYL_LOW     = 8'h10;
   localparam logic [7:0] OFS_CYL_HIGH    = 8'h14;
   localparam logic [7:0] OFS_DEV_HEAD    = 8'h18;
   localparam logic [7:0] OFS_CMD_STATUS  = 8'h1C;
   localparam logic [7:0] OFS_ERROR       = 8'h20;
   localparam logic [7:0] OFS_DEV_CONTROL = 8'h24;

   // command codes
   localparam logic [7:0] CMD_READ_DMA      = 8'hC8;
   localparam logic [7:0] CMD_READ_DMA_MASK = 8'hFE;
   localparam logic [7:0] CMD_READ_DMA_EXT  = 8'h25;

   // field positions
   localparam int LBA_MODE_BIT   = 6;
   localparam int HOB_BIT        = 7;
   localparam int ST_BUSY_BIT    = 7;
   localparam int ST_READY_BIT   = 6;
   localparam int ST_SEEK_BIT    = 4;
   localparam int ST_DRQ_BIT     = 3;
   localparam int ST_ERR_BIT     = 0;
   localparam int ERR_UNC_BIT    = 6;
   localparam int ERR_ABORT_BIT  = 2;

   // reset values
   localparam logic [7:0] TF_RESET      = 8'h00;
   localparam logic [7:0] DEV_HEAD_RST  = 8'hA0;
   localparam logic [7:0] ERR_RESET     = 8'h00;

   // transfer sizes
   localparam logic [7:0]  WORDS_PER_SECTOR_M1 = 8'hFF;
   localparam logic [16:0] COUNT28_ZERO_AS     = 17'h00100;
   localparam logic [16:0] COUNT48_ZERO_AS     = 17'h10000;

   // chs geometry defaults
   localparam logic [7:0] SECTORS_PER_TRACK = 8'h3F;
   localparam logic [3:0] HEADS_M1          = 4'hF;

   // a task-file register holding the last two writes
   typedef struct packed {
      logic [7:0] prev;
      logic [7:0] cur;
   } rdcd_tf_s;

endpackage

// ### sim/rdcd_monitor.sv
// rdcd_monitor: port assertions for the read dma command decoder.
// assumes it is bound into rdcd_top; one clock, active-high reset.
`timescale 1ns/1ns
module rdcd_monitor (
   input wire logic        clk_i,
   input wire logic        rst_i,
   input wire logic        wb_cyc_i,
   input wire logic        wb_stb_i,
   input wire logic        wb_ack_o,
   input wire logic [31:0] wb_dat_o,
   input wire logic        dmarq_o,
   input wire logic [15:0] dma_data_o,
   input wire logic        dmack_i,
   input wire logic        intrq_o,
   input wire logic        media_req_o,
   input wire logic        media_vld_i,
   input wire logic [15:0] media_word_i,
   input wire logic        media_unc_i
);
   default clocking cb @(posedge clk_i); endclocking
   default disable iff (rst_i);

   // bus handshake: answer next cycle, one cycle wide, upper bytes zero
   a_ack_next_cycle:
      assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
      else $error("ack late");
   a_ack_single_pulse:
      assert property (wb_ack_o |=> !wb_ack_o)
      else $error("ack wider than one cycle");
   a_read_upper_zero:
      assert property (wb_ack_o |-> wb_dat_o[31:8] == 24'h000000)
      else $error("read data upper bytes set");
   // a media word is offered to the host one cycle after it arrives
   a_word_offered:
      assert property (media_req_o && media_vld_i && !media_unc_i
         |=> dmarq_o && dma_data_o == $past(media_word_i))
      else $error("media word not offered");
   // four quiet acknowledge samples cannot have taken the word yet
   a_word_held:
      assert property ((!dmack_i)[*4] ##0 dmarq_o |=> dmarq_o && $stable(dma_data_o))
      else $error("word dropped without acknowledge");
   a_one_word_flight:
      assert property (!(media_req_o && dmarq_o))
      else $error("media fetch while word pending");
   a_unc_stops_read:
      assert property (media_req_o && media_unc_i |=> intrq_o && !media_req_o && !dmarq_o)
      else $error("read went on after media error");
   a_irq_when_idle:
      assert property ($rose(intrq_o) |-> !media_req_o && !dmarq_o)
      else $error("interrupt during transfer");
endmodule // rdcd_monitor

// ### sim/rdcd_host_dma.sv
// rdcd_host_dma: host slave-dma channel taking words paced by dmarq.
// assumes the device clock; the bench arms it and sets the gap.
`timescale 1ns/1ns
module rdcd_host_dma (
   input  wire logic        clk_i,
   input  wire logic        rst_i,
   input  wire logic        armed_i,
   input  wire logic [3:0]  gap_i,
   input  wire logic        dmarq_i,
   input  wire logic [15:0] dma_data_i,
   output logic             dmack_o,
   output logic             took_o,
   output logic      [15:0] word_o
);
   logic [3:0] low_cnt;

   // acknowledge only after gap_i low cycles: a slow host, and the
   // device always sees a clean rise after a stable low
   always_ff @(posedge clk_i) begin
      took_o <= 1'b0;
      if (rst_i) begin
         dmack_o <= 1'b0;
         low_cnt <= 4'h0;
      end else if (dmack_o) begin
         if (!dmarq_i) dmack_o <= 1'b0;
      end else begin
         low_cnt <= (low_cnt == 4'hF) ? low_cnt : low_cnt + 4'h1;
         if (armed_i && dmarq_i && low_cnt >= gap_i) begin
            dmack_o <= 1'b1;
            took_o  <= 1'b1;
            word_o  <= dma_data_i;
            low_cnt <= 4'h0;
         end
      end
   end
endmodule // rdcd_host_dma

// ### sim/test_read_dma_command_decoder.sv
// test_read_dma_command_decoder: self-checking bench for rdcd_top.
// assumes the package, monitor and host dma model are compiled first.
`timescale 1ns/1ns
module test_read_dma_command_decoder;
   logic        clk_i = 1'b0, rst_i = 1'b1, wb_cyc_i = 1'b0, wb_stb_i = 1'b0;
   logic        wb_we_i = 1'b0, wb_ack_o, dmarq_o, dmack_i, intrq_o, media_req_o;
   logic        media_vld_i = 1'b0, media_unc_i = 1'b0, took, armed = 1'b0, irq_d;
   logic [7:0]  wb_adr_i = 8'h00;
   logic [31:0] wb_dat_i = 32'h0, wb_dat_o, seed = 32'h8F3A;
   logic [15:0] dma_data_o, word, media_word_i = 16'h0000;
   logic [47:0] media_lba_o;
   logic [3:0]  gap = 4'h2;
   logic [15:0] dq[$];
   logic [7:0]  rq[$];
   int          errors = 0, n_tests = 0, nw = 0, unc_at = -1, irqs = 0;

   always #4 clk_i = ~clk_i;

   rdcd_top rdcd_top_inst (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i),
      .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(4'h1),
      .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .dmarq_o(dmarq_o),
      .dma_data_o(dma_data_o), .dmack_i(dmack_i), .intrq_o(intrq_o),
      .media_req_o(media_req_o), .media_lba_o(media_lba_o), .media_vld_i(media_vld_i),
      .media_word_i(media_word_i), .media_unc_i(media_unc_i));
   rdcd_host_dma rdcd_host_dma_inst (.clk_i(clk_i), .rst_i(rst_i), .armed_i(armed),
      .gap_i(gap), .dmarq_i(dmarq_o), .dma_data_i(dma_data_o), .dmack_o(dmack_i),
      .took_o(took), .word_o(word));

   function automatic logic [31:0] lfsr_next(input logic [31:0] s);
      return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
   endfunction

   task automatic check(input string what, input logic [47:0] exp, input logic [47:0] got);
      n_tests++;
      if (got !== exp) begin
         errors++;
         $display("ERROR %s expected %h seen %h", what, exp, got);
      end
   endtask

   task automatic check_reg(input logic [7:0] exp, input logic [31:0] got);
      check("register", {40'h0000000000, exp}, {16'h0000, got});
   endtask

   task automatic check_word(input logic [15:0] exp, input logic [15:0] got);
      check("dma word", {32'h00000000, exp}, {32'h00000000, got});
   endtask

   task automatic give_verdict();
      $display("checks %0d mismatches %0d", n_tests, errors);
      if (errors == 0 && n_tests > 0) $display("STATUS OK");
      else $display("STATUS NOT OK");
      $finish;
   endtask

   task automatic timed_out(input string what);
      errors++;
      $display("ERROR %s expected done seen timeout", what);
      give_verdict();
   endtask

   // one classic cycle; held until ack is sampled, then released
   task automatic wb(input logic we, input logic [7:0] adr, input logic [7:0] dat);
      int i;
      @(posedge clk_i);
      wb_cyc_i <= 1'b1;
      wb_stb_i <= 1'b1;
      wb_we_i  <= we;
      wb_adr_i <= adr;
      wb_dat_i <= {24'h000000, dat};
      for (i = 0; i < 20; i++) begin
         @(posedge clk_i);
         if (wb_ack_o === 1'b1) break;
      end
      if (i == 20) timed_out("wishbone ack");
      wb_cyc_i <= 1'b0;
      wb_stb_i <= 1'b0;
   endtask

   task automatic rd_chk(input logic [7:0] adr, input logic [7:0] exp);
      rq.push_back(exp);
      wb(1'b0, adr, 8'h00);
   endtask

   task automatic wait_hi(input logic irq);
      int i;
      for (i = 0; i < 30000; i++) begin
         @(posedge clk_i);
         if ((irq ? intrq_o : media_req_o) === 1'b1) break;
      end
      if (i == 30000) timed_out("transfer");
   endtask

   // task file bytes go previous first, then current, per register
   task automatic run(input logic [7:0] cmd, input logic [63:0] tf, input logic [7:0] dh,
                      input logic [47:0] lba);
      int i;
      for (i = 0; i < 8; i++)
         wb(1'b1, rdcd_pkg::OFS_SECTOR_CNT + 8'(4 * (i / 2)), tf[63 - 8 * i -: 8]);
      wb(1'b1, rdcd_pkg::OFS_DEV_HEAD, dh);
      nw = 0;
      irqs = 0;
      armed <= 1'b1;
      wb(1'b1, rdcd_pkg::OFS_CMD_STATUS, cmd);
      wait_hi(1'b0);
      check("media lba", lba, media_lba_o);
      wait_hi(1'b1);
      repeat (20) @(posedge clk_i);
      check("interrupt count", 48'h1, 48'(irqs));
      check("words left", 48'h0, 48'(dq.size()));
   endtask

   // media source: random stalls and data, words noted before they are sent
   always @(posedge clk_i) begin
      seed = lfsr_next(seed);
      gap <= 4'(2 + seed[3:1]);
      if (media_req_o === 1'b1 && !media_vld_i && !media_unc_i && seed[0]) begin
         if (nw == unc_at) media_unc_i <= 1'b1;
         else begin
            media_vld_i  <= 1'b1;
            media_word_i <= seed[31:16];
            dq.push_back(seed[31:16]);
         end
         nw++;
      end else begin
         media_vld_i  <= 1'b0;
         media_unc_i  <= 1'b0;
         media_word_i <= ~media_word_i; // no stale word looks valid
      end
   end

   // results as they appear, against the oldest note
   always @(posedge clk_i) begin
      irq_d <= intrq_o;
      if (intrq_o === 1'b1 && irq_d !== 1'b1) irqs++;
      if (wb_ack_o === 1'b1 && wb_we_i === 1'b0)
         check_reg((rq.size() > 0) ? rq.pop_front() : 8'hXX, wb_dat_o);
      if (took === 1'b1)
         check_word((dq.size() > 0) ? dq.pop_front() : 16'hXXXX, word);
   end

   initial begin
      repeat (6) @(posedge clk_i);
      rst_i <= 1'b0;
      rd_chk(rdcd_pkg::OFS_CMD_STATUS, 8'h50);
      rd_chk(rdcd_pkg::OFS_DEV_HEAD, rdcd_pkg::DEV_HEAD_RST);
      rd_chk(8'h40, 8'h00);
      // lba mode, retry bit set, last sector carries into the second byte
      run(8'hC9, 64'h0002_00FF_00C1_00A3, 8'hE7, 48'h7A3C1FF);
      rd_chk(rdcd_pkg::OFS_SECTOR_CNT, 8'h00);
      rd_chk(rdcd_pkg::OFS_SECTOR_NUM, 8'h00);
      rd_chk(rdcd_pkg::OFS_CYL_LOW, 8'hC2);
      rd_chk(rdcd_pkg::OFS_CYL_HIGH, 8'hA3);
      rd_chk(rdcd_pkg::OFS_DEV_HEAD, 8'hE7);
      rd_chk(rdcd_pkg::OFS_CMD_STATUS, 8'h50);
      // chs mode, plain code
      run(8'hC8, 64'h0001_0001_0003_0002, 8'hA2, 48'h2020301);
      rd_chk(rdcd_pkg::OFS_SECTOR_NUM, 8'h01);
      rd_chk(rdcd_pkg::OFS_CYL_LOW, 8'h03);
      rd_chk(rdcd_pkg::OFS_CYL_HIGH, 8'h02);
      rd_chk(rdcd_pkg::OFS_DEV_HEAD, 8'hA2);
      // extended read of 258 sectors, media error on the second sector
      unc_at = 256;
      run(8'h25, 64'h0102_1234_5678_9ABC, 8'h40, 48'h9A5612BC7834);
      unc_at = -1;
      rd_chk(rdcd_pkg::OFS_CMD_STATUS, 8'h51);
      rd_chk(rdcd_pkg::OFS_ERROR, 8'h40);
      rd_chk(rdcd_pkg::OFS_SECTOR_CNT, 8'h01);
      rd_chk(rdcd_pkg::OFS_SECTOR_NUM, 8'h35);
      rd_chk(rdcd_pkg::OFS_CYL_LOW, 8'h78);
      rd_chk(rdcd_pkg::OFS_CYL_HIGH, 8'hBC);
      wb(1'b1, rdcd_pkg::OFS_DEV_CONTROL, 8'h80);
      rd_chk(rdcd_pkg::OFS_SECTOR_NUM, 8'h12);
      rd_chk(rdcd_pkg::OFS_CYL_LOW, 8'h56);
      rd_chk(rdcd_pkg::OFS_CYL_HIGH, 8'h9A);
      rd_chk(rdcd_pkg::OFS_SECTOR_CNT, 8'h01);
      // zero counts ask for the most sectors; one sector moves, then an error
      unc_at = 256;
      run(8'h25, 64'h0, 8'h40, 48'h0);
      rd_chk(rdcd_pkg::OFS_SECTOR_CNT, 8'hFF);
      wb(1'b1, rdcd_pkg::OFS_DEV_CONTROL, 8'h80);
      rd_chk(rdcd_pkg::OFS_SECTOR_CNT, 8'hFF);
      run(8'hC8, 64'h0, 8'hE0, 48'h0);
      rd_chk(rdcd_pkg::OFS_SECTOR_CNT, 8'hFF);
      rd_chk(rdcd_pkg::OFS_SECTOR_NUM, 8'h01);
      give_verdict();
   end
endmodule // test_read_dma_command_decoder

bind rdcd_top rdcd_monitor rdcd_monitor_inst (.clk_i(clk_i), .rst_i(rst_i),
   .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_ack_o(wb_ack_o), .wb_dat_o(wb_dat_o),
   .dmarq_o(dmarq_o), .dma_data_o(dma_data_o), .dmack_i(dmack_i), .intrq_o(intrq_o),
   .media_req_o(media_req_o), .media_vld_i(media_vld_i), .media_word_i(media_word_i),
   .media_unc_i(media_unc_i));
